// ---- hdl/dcpwm_top.sv ----
// two-channel 10-bit down-count timer with pwm and tone outputs, wishbone slave
// assumes external tick pins already synchronous to CLK; pad muxing lives outside
// Overview of operation
// - 10-bit down counter, prescaler, auto reload
// - high bits first, reload applied at underflow
// - disabled: low reload write loads counter now
// - count read returns live counter
// - enable bit runs; source bit picks pin
// - edge bit: one falling, zero rising
// - prescaler on when bit low, 1:2..1:256
// - prescaler count readable
// - one-shot counts down once then stops
// - continuous restart from reload or 0x3FF
// - channel one flag bit 3, gated irq
// - flag held until software writes zero
// - wave enable drives pin, output direction
// - polarity bit one means active low
// - duty zero never active, 10-bit duty
// - duty high bits first, applied at underflow
// - tone enable drives tone pin as output
// - tone source prescaler or counter, divided
// - channel two uses second tick pin
// - channel two high bits at 7:6, 3:2
// - channel two flag bit 5, gated irq
module dcpwm_top
  import dcpwm_pkg::*;
#(
  parameter int INSTR_DIV = 4
)
(
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic [31:0]      WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        EXT_TICK_PIN_A,
  input  wire logic        EXT_TICK_PIN_B,
  output logic             CH1_WAVE_PIN,
  output logic             CH1_WAVE_PIN_OE_N,
  output logic             CH1_TONE_PIN,
  output logic             CH1_TONE_PIN_OE_N,
  output logic             CH2_WAVE_PIN,
  output logic             CH2_WAVE_PIN_OE_N,
  output logic             CH2_TONE_PIN,
  output logic             CH2_TONE_PIN_OE_N,
  output logic             IRQ
);

  localparam logic [7:0] INSTR_LAST = 8'(INSTR_DIV - 1);

  dcpwm_state_t   q;
  dcpwm_state_t   d;
  logic           req;
  logic           wr;
  logic [7:0]     wdat;
  logic           instr_tick;
  logic [NCH-1:0] pin_now;
  logic [NCH-1:0] src_tick;
  logic [NCH-1:0] ps_out;
  logic [NCH-1:0] ps_clr;
  logic [NCH-1:0] run;
  logic [NCH-1:0] cnt_tick;
  logic [NCH-1:0] uf;
  logic [NCH-1:0] tone_in;
  logic [NCH-1:0] tone_tick;
  logic [7:0]     ps_val [NCH];

  function automatic logic hit(input logic [7:0] adr, input int ch, input logic [7:0] off);
    return adr == 8'(off + 8'(ch) * CH_STRIDE);
  endfunction

  assign req        = WB_CYC_I & WB_STB_I;
  // writes land on the edge that sees ack, as the master expects
  assign wr         = req & WB_WE_I & q.ack & WB_SEL_I[0];
  assign wdat       = WB_DAT_I[7:0];
  assign instr_tick = q.instr_cnt == INSTR_LAST;
  assign pin_now    = {EXT_TICK_PIN_B, EXT_TICK_PIN_A};

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic rise;
      logic fall;
      // pins are synchronous already, so one stage suffices for the edge
      assign rise = pin_now[g] & ~q.ext_prev[g];
      assign fall = ~pin_now[g] & q.ext_prev[g];
      assign src_tick[g] = q.ch[g].ctl2[B_SRC] ?
                           (q.ch[g].ctl2[B_EDGE] ? fall : rise) : instr_tick;
      assign ps_clr[g] = wr & hit(WB_ADR_I, g, A_CTL2);
      assign run[g] = q.ch[g].ctl1[B_EN] & ~q.ch[g].stopped;
      assign cnt_tick[g] = run[g] & (q.ch[g].ctl2[B_PS_EN_N] ? src_tick[g] : ps_out[g]);
      assign uf[g] = cnt_tick[g] & (q.ch[g].count == COUNT_ZERO);
      assign tone_in[g] = q.ch[g].tone[B_TONE_SRC] ? uf[g] : ps_out[g];

      dcpwm_div u_pre (
        .CLK      (CLK),
        .RESETN   (RESETN),
        .clear    (ps_clr[g]),
        .tick_in  (src_tick[g] & q.ch[g].ctl1[B_EN]),
        .ratio    (q.ch[g].ctl2[B_RATIO +: 3]),
        .tick_out (ps_out[g]),
        .value    (ps_val[g])
      );

      dcpwm_div u_tone (
        .CLK      (CLK),
        .RESETN   (RESETN),
        .clear    (~q.ch[g].tone[B_TONE_EN]),
        .tick_in  (tone_in[g]),
        .ratio    (q.ch[g].tone[B_RATIO +: 3]),
        .tick_out (tone_tick[g]),
        .value    ()
      );
    end
  endgenerate

  always_comb begin
    logic [CW-1:0] rld;
    logic [CW-1:0] dty;
    rld = COUNT_ZERO;
    dty = COUNT_ZERO;
    d = q;
    d.ack = req & ~q.ack;
    d.ext_prev = pin_now;
    d.instr_cnt = instr_tick ? RST_BYTE : q.instr_cnt + 8'h01;
    d.irq = |(q.iflag & q.ien & IFLAG_MASK) & q.ien[B_GIE];
    if (wr && WB_ADR_I == A_HIGH) begin
      d.high = wdat;
    end
    if (wr && WB_ADR_I == A_IEN) begin
      d.ien = wdat & IEN_MASK;
    end
    // only a written zero clears; a one leaves the flag alone
    if (wr && WB_ADR_I == A_IFLAG) begin
      d.iflag = q.iflag & wdat & IFLAG_MASK;
    end
    d.rdata = '0;
    if (req && !q.ack) begin
      if (WB_ADR_I == A_HIGH) begin
        d.rdata[7:0] = q.high;
      end
      if (WB_ADR_I == A_IFLAG) begin
        d.rdata[7:0] = q.iflag;
      end
      if (WB_ADR_I == A_IEN) begin
        d.rdata[7:0] = q.ien;
      end
    end
    for (int i = 0; i < NCH; i++) begin
      rld = {q.high[RLD_HI_POS[i] +: 2], wdat};
      dty = {q.high[DUTY_HI_POS[i] +: 2], wdat};
      if (req && !q.ack) begin
        if (hit(WB_ADR_I, i, A_CTL1)) begin
          d.rdata[7:0] = q.ch[i].ctl1;
        end
        if (hit(WB_ADR_I, i, A_CTL2)) begin
          d.rdata[7:0] = q.ch[i].ctl2;
        end
        if (hit(WB_ADR_I, i, A_COUNT)) begin
          d.rdata[CW-1:0] = q.ch[i].count;
        end
        if (hit(WB_ADR_I, i, A_DUTY)) begin
          d.rdata[CW-1:0] = q.ch[i].duty_buf;
        end
        if (hit(WB_ADR_I, i, A_PSVAL)) begin
          d.rdata[7:0] = ps_val[i];
        end
        if (hit(WB_ADR_I, i, A_TONE)) begin
          d.rdata[7:0] = q.ch[i].tone;
        end
      end
      if (cnt_tick[i]) begin
        if (uf[i]) begin
          d.iflag[FLAG_POS[i]] = 1'b1;
          d.ch[i].duty_act = q.ch[i].duty_buf;
          if (q.ch[i].ctl1[B_ONE_SHOT]) begin
            d.ch[i].stopped = 1'b1;
          end else begin
            d.ch[i].count = q.ch[i].ctl1[B_RELOAD_SEL] ? q.ch[i].reload_buf : COUNT_MAX;
            d.ch[i].top = d.ch[i].count;
          end
        end else begin
          d.ch[i].count = q.ch[i].count - 10'h001;
        end
      end
      if (wr && hit(WB_ADR_I, i, A_CTL1)) begin
        d.ch[i].ctl1 = wdat;
        d.ch[i].stopped = 1'b0;
      end
      if (wr && hit(WB_ADR_I, i, A_CTL2)) begin
        d.ch[i].ctl2 = wdat;
      end
      if (wr && hit(WB_ADR_I, i, A_TONE)) begin
        d.ch[i].tone = wdat;
      end
      if (wr && hit(WB_ADR_I, i, A_COUNT)) begin
        d.ch[i].reload_buf = rld;
        if (!q.ch[i].ctl1[B_EN]) begin
          d.ch[i].count = rld;
          d.ch[i].top = rld;
          d.ch[i].stopped = 1'b0;
        end
      end
      if (wr && hit(WB_ADR_I, i, A_DUTY)) begin
        d.ch[i].duty_buf = dty;
        if (!q.ch[i].ctl1[B_EN]) begin
          d.ch[i].duty_act = dty;
        end
      end
      // duty above the period would simply saturate to always active
      d.ch[i].wave = q.ch[i].ctl1[B_WAVE_OE] &
                     ((run[i] & ((q.ch[i].top - q.ch[i].count) < q.ch[i].duty_act)) ^
                      q.ch[i].ctl1[B_POL]);
      if (!q.ch[i].tone[B_TONE_EN]) begin
        d.ch[i].tone_lvl = 1'b0;
      end else if (tone_tick[i]) begin
        d.ch[i].tone_lvl = ~q.ch[i].tone_lvl;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign WB_ACK_O          = q.ack;
  assign WB_DAT_O          = q.rdata;
  assign IRQ               = q.irq;
  assign CH1_WAVE_PIN      = q.ch[0].wave;
  assign CH1_WAVE_PIN_OE_N = ~q.ch[0].ctl1[B_WAVE_OE];
  assign CH1_TONE_PIN      = q.ch[0].tone_lvl;
  assign CH1_TONE_PIN_OE_N = ~q.ch[0].tone[B_TONE_EN];
  assign CH2_WAVE_PIN      = q.ch[1].wave;
  assign CH2_WAVE_PIN_OE_N = ~q.ch[1].ctl1[B_WAVE_OE];
  assign CH2_TONE_PIN      = q.ch[1].tone_lvl;
  assign CH2_TONE_PIN_OE_N = ~q.ch[1].tone[B_TONE_EN];

  sequence s_one_shot_uf;
    uf[0] && q.ch[0].ctl1[B_ONE_SHOT];
  endsequence

  sequence s_frozen;
    (!run[0] && q.ch[0].count == COUNT_ZERO) [*3];
  endsequence

  property p_one_shot_stop;
    @(posedge CLK) disable iff (!RESETN)
      s_one_shot_uf ##1 !(req && WB_WE_I) [*3] |-> ##1 s_frozen;
  endproperty
  a_one_shot_stop: assert property (p_one_shot_stop) else $error("one-shot kept counting");

  property p_restart_max;
    @(posedge CLK) disable iff (!RESETN)
      (uf[0] && !q.ch[0].ctl1[B_ONE_SHOT] && !q.ch[0].ctl1[B_RELOAD_SEL] && !wr)
        |=> q.ch[0].count == COUNT_MAX;
  endproperty
  a_restart_max: assert property (p_restart_max) else $error("no restart from full count");

  property p_restart_reload;
    @(posedge CLK) disable iff (!RESETN)
      (uf[1] && !q.ch[1].ctl1[B_ONE_SHOT] && q.ch[1].ctl1[B_RELOAD_SEL] && !wr)
        |=> q.ch[1].count == $past(q.ch[1].reload_buf);
  endproperty
  a_restart_reload: assert property (p_restart_reload) else $error("no restart from reload");

  property p_load_disabled;
    @(posedge CLK) disable iff (!RESETN)
      (wr && WB_ADR_I == A_COUNT && !q.ch[0].ctl1[B_EN])
        |=> q.ch[0].count == {$past(q.high[5:4]), $past(wdat)};
  endproperty
  a_load_disabled: assert property (p_load_disabled) else $error("disabled load missed");

  property p_hold_enabled;
    @(posedge CLK) disable iff (!RESETN)
      (wr && WB_ADR_I == A_COUNT && q.ch[0].ctl1[B_EN] && !cnt_tick[0])
        |=> $stable(q.ch[0].count);
  endproperty
  a_hold_enabled: assert property (p_hold_enabled) else $error("enabled load hit counter");

  property p_idle_still;
    @(posedge CLK) disable iff (!RESETN)
      (!q.ch[0].ctl1[B_EN] && !wr) |=> $stable(q.ch[0].count);
  endproperty
  a_idle_still: assert property (p_idle_still) else $error("counter moved while off");

  property p_count_read;
    @(posedge CLK) disable iff (!RESETN)
      (req && !q.ack && !WB_WE_I && WB_ADR_I == A_COUNT)
        |=> WB_ACK_O && WB_DAT_O[CW-1:0] == $past(q.ch[0].count);
  endproperty
  a_count_read: assert property (p_count_read) else $error("count read not live");

  property p_flag_set;
    @(posedge CLK) disable iff (!RESETN)
      uf[0] |=> q.iflag[3];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("underflow flag not set");

  property p_flag2_set;
    @(posedge CLK) disable iff (!RESETN)
      uf[1] |=> q.iflag[5];
  endproperty
  a_flag2_set: assert property (p_flag2_set) else $error("channel two flag not set");

  property p_flag_hold;
    @(posedge CLK) disable iff (!RESETN)
      $fell(q.iflag[3]) |-> $past(wr && WB_ADR_I == A_IFLAG && !wdat[3]);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag cleared by itself");

  property p_irq_gate;
    @(posedge CLK) disable iff (!RESETN)
      IRQ |-> $past(q.ien[B_GIE]) && $past(|(q.iflag & q.ien & IFLAG_MASK));
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enables");

  property p_duty_zero;
    @(posedge CLK) disable iff (!RESETN)
      (q.ch[0].ctl1[B_WAVE_OE] && q.ch[0].duty_act == COUNT_ZERO)
        |=> CH1_WAVE_PIN == $past(q.ch[0].ctl1[B_POL]);
  endproperty
  a_duty_zero: assert property (p_duty_zero) else $error("zero duty went active");

endmodule

// ---- hdl/dcpwm_pkg.sv ----
// constants, register map and state types of the dual down-count timer
// assumes 8-bit register writes in the low byte of a 32-bit wishbone word; count and duty read back 10 bits
package dcpwm_pkg;

  localparam int NCH = 2;
  localparam int CW  = 10;

  // byte addresses; channel two sits one stride above channel one
  localparam logic [7:0] A_CTL1    = 8'h00;
  localparam logic [7:0] A_CTL2    = 8'h04;
  localparam logic [7:0] A_COUNT   = 8'h08;
  localparam logic [7:0] A_DUTY    = 8'h0C;
  localparam logic [7:0] A_PSVAL   = 8'h10;
  localparam logic [7:0] A_TONE    = 8'h14;
  localparam logic [7:0] CH_STRIDE = 8'h20;
  localparam logic [7:0] A_HIGH    = 8'h40;
  localparam logic [7:0] A_IFLAG   = 8'h44;
  localparam logic [7:0] A_IEN     = 8'h48;

  // control one
  localparam int B_EN         = 0;
  localparam int B_RELOAD_SEL = 1;
  localparam int B_ONE_SHOT   = 2;
  localparam int B_POL        = 6;
  localparam int B_WAVE_OE    = 7;
  // control two
  localparam int B_RATIO      = 0;
  localparam int B_PS_EN_N    = 3;
  localparam int B_EDGE       = 4;
  localparam int B_SRC        = 5;
  // tone control
  localparam int B_TONE_SRC   = 3;
  localparam int B_TONE_EN    = 7;
  // interrupt registers and high register bit positions
  localparam int B_GIE        = 7;
  localparam int FLAG_POS    [NCH] = '{3, 5};
  localparam int RLD_HI_POS  [NCH] = '{4, 6};
  localparam int DUTY_HI_POS [NCH] = '{0, 2};

  localparam logic [7:0]    IFLAG_MASK = 8'h28;
  localparam logic [7:0]    IEN_MASK   = 8'hA8;
  localparam logic [7:0]    RST_BYTE   = 8'h00;
  localparam logic [CW-1:0] COUNT_MAX  = 10'h3FF;
  localparam logic [CW-1:0] COUNT_ZERO = 10'h000;
  localparam logic [2:0]    RATIO_TOP  = 3'h7;
  localparam logic [7:0]    DIV_FULL   = 8'hFF;

  typedef struct packed {
    logic [7:0]    ctl1;
    logic [7:0]    ctl2;
    logic [7:0]    tone;
    logic [CW-1:0] reload_buf;
    logic [CW-1:0] duty_buf;
    logic [CW-1:0] duty_act;
    logic [CW-1:0] top;
    logic [CW-1:0] count;
    logic          stopped;
    logic          wave;
    logic          tone_lvl;
  } dcpwm_ch_t;

  typedef struct packed {
    dcpwm_ch_t [NCH-1:0] ch;
    logic [7:0]          high;
    logic [7:0]          iflag;
    logic [7:0]          ien;
    logic [NCH-1:0]      ext_prev;
    logic [7:0]          instr_cnt;
    logic                ack;
    logic [31:0]         rdata;
    logic                irq;
  } dcpwm_state_t;

  typedef struct packed {
    logic [7:0] cnt;
  } dcpwm_div_state_t;

  // ratio code n divides by 2**(n+1)
  function automatic logic [7:0] ratio_mask(input logic [2:0] n);
    return DIV_FULL >> (RATIO_TOP - n);
  endfunction

endpackage

// ---- hdl/dcpwm_div.sv ----
// power-of-two tick divider, used as prescaler and as tone divider
// assumes tick_in is a one-cycle enable pulse in the CLK domain
module dcpwm_div
  import dcpwm_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RESETN,
  input  wire logic       clear,
  input  wire logic       tick_in,
  input  wire logic [2:0] ratio,
  output logic            tick_out,
  output logic [7:0]      value
);

  dcpwm_div_state_t q;
  dcpwm_div_state_t d;
  logic [7:0]       mask;

  assign mask     = ratio_mask(ratio);
  assign tick_out = tick_in & ((q.cnt & mask) == mask);
  assign value    = q.cnt;

  always_comb begin
    d = q;
    if (clear) begin
      d.cnt = RST_BYTE;
    end else if (tick_in) begin
      d.cnt = q.cnt + 8'h01;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

// ---- verification/dcpwm_top_bench.sv ----
// self-checking bench for the dual down-count timer, drives wishbone and tick pins
// assumes the design assertions sit in the design files; one clock, sync reset
module dcpwm_top_bench
  import dcpwm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        rst_n;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        pin_a;
  logic        pin_b;
  logic        wave1;
  logic        wave1_oe_n;
  logic        tone1;
  logic        tone1_oe_n;
  logic        wave2;
  logic        wave2_oe_n;
  logic        tone2;
  logic        tone2_oe_n;
  logic        irq;
  int          error_cnt;
  int          total_checks;

  // fastest instruction tick keeps periods short
  dcpwm_top #(.INSTR_DIV(1)) i_dut (
    .CLK(clk), .RESETN(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .EXT_TICK_PIN_A(pin_a),
    .EXT_TICK_PIN_B(pin_b), .CH1_WAVE_PIN(wave1), .CH1_WAVE_PIN_OE_N(wave1_oe_n), .CH1_TONE_PIN(tone1),
    .CH1_TONE_PIN_OE_N(tone1_oe_n), .CH2_WAVE_PIN(wave2), .CH2_WAVE_PIN_OE_N(wave2_oe_n),
    .CH2_TONE_PIN(tone2), .CH2_TONE_PIN_OE_N(tone2_oe_n), .IRQ(irq)
  );

  always #2 clk = ~clk;

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_b(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // entered and left just after a rising edge; leaves one idle cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
    if (n >= 40) begin
      error_cnt++;
      end_sim();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 8'h00, q);
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask

  // only the selected pin pulses; the other one is held low
  task automatic pulse(input bit b, input int n);
    repeat (n) begin
      pin_a <= ~b;
      pin_b <= b;
      wait_n(4);
      pin_a <= 1'b0;
      pin_b <= 1'b0;
      wait_n(4);
    end
  endtask

  // counts wave high samples and tone changes of channel c
  task automatic watch(input bit c, input int n, output int hi, output int tg);
    logic last;
    hi = 0;
    tg = 0;
    last = c ? tone2 : tone1;
    repeat (n) begin
      @(posedge clk);
      if ((c ? wave2 : wave1) === 1'b1) begin
        hi++;
      end
      if ((c ? tone2 : tone1) !== last) begin
        tg++;
      end
      last = c ? tone2 : tone1;
    end
  endtask

  task automatic t_reset();
    logic [31:0] q;
    chk_b(wave1_oe_n & tone1_oe_n & wave2_oe_n & tone2_oe_n, 1'b1);
    chk_b(irq, 1'b0);
    rd(A_CTL1, q);
    chk_w(q, 32'h00000000);
    rd(A_IFLAG, q);
    chk_w(q, 32'h00000000);
    wr(8'h3C, 8'h5A);
    rd(8'h3C, q);
    chk_w(q, 32'h00000000);
    wr(A_HIGH, 8'h01);
    wr(A_DUTY, 8'h05);
    rd(A_DUTY, q);
    chk_w(q, 32'h00000105);
    wr(A_HIGH, 8'h10);
    wr(A_COUNT, 8'h23);
    rd(A_COUNT, q);
    chk_w(q, 32'h00000123);
    wr(A_HIGH, 8'h00);
    wr(A_DUTY, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_oneshot();
    logic [31:0] q;
    wr(A_COUNT, 8'h05);
    wr(A_CTL2, 8'h08);
    wr(A_IEN, 8'h88);
    wr(A_CTL1, 8'h05);
    wait_n(30);
    rd(A_COUNT, q);
    chk_w(q, 32'h00000000);
    // enabled but stopped: a low reload write must only be buffered
    wr(A_COUNT, 8'h09);
    rd(A_COUNT, q);
    chk_w(q, 32'h00000000);
    rd(A_IFLAG, q);
    chk_w(q, 32'h00000008);
    wait_n(20);
    chk_b(irq, 1'b1);
    rd(A_IFLAG, q);
    chk_w(q, 32'h00000008);
    wr(A_IFLAG, 8'h00);
    rd(A_IFLAG, q);
    chk_w(q, 32'h00000000);
    chk_b(irq, 1'b0);
    wr(A_CTL1, 8'h00);
    $display("test one-shot done");
  endtask

  task automatic t_reload();
    logic [31:0] q;
    logic [9:0]  mx;
    wr(A_COUNT, 8'h03);
    wr(A_CTL1, 8'h01);
    wait_n(12);
    rd(A_COUNT, q);
    chk_b(q[9:0] >= 10'h3F0, 1'b1);
    wr(A_CTL1, 8'h00);
    wr(A_COUNT, 8'h03);
    rd(A_COUNT, q);
    chk_w(q, 32'h00000003);
    wr(A_CTL1, 8'h03);
    // period is four cycles; this phase puts the read before the next underflow
    wait_n(18);
    wr(A_COUNT, 8'h07);
    rd(A_COUNT, q);
    chk_b(q[9:0] <= 10'h003, 1'b1);
    wait_n(20);
    mx = 10'h000;
    repeat (8) begin
      rd(A_COUNT, q);
      if (q[9:0] > mx) begin
        mx = q[9:0];
      end
    end
    chk_b(mx > 10'h003 && mx <= 10'h007, 1'b1);
    wr(A_CTL1, 8'h00);
    wr(A_IFLAG, 8'h00);
    $display("test reload done");
  endtask

  task automatic t_ext();
    logic [31:0] q;
    int          hi;
    int          tg;
    wr(A_HIGH, 8'h40);
    wr(A_COUNT + CH_STRIDE, 8'h05);
    wr(A_CTL2 + CH_STRIDE, 8'h28);
    pulse(1'b1, 1);
    rd(A_COUNT + CH_STRIDE, q);
    chk_w(q, 32'h00000105);
    wr(A_CTL1 + CH_STRIDE, 8'h01);
    pulse(1'b1, 3);
    rd(A_COUNT + CH_STRIDE, q);
    chk_w(q, 32'h00000102);
    wr(A_CTL2 + CH_STRIDE, 8'h38);
    pulse(1'b1, 2);
    rd(A_COUNT + CH_STRIDE, q);
    chk_w(q, 32'h00000100);
    wr(A_CTL1 + CH_STRIDE, 8'h00);
    wr(A_HIGH, 8'h00);
    wr(A_COUNT + CH_STRIDE, 8'h01);
    // reload select on, so the underflow restarts from the stored value
    wr(A_CTL1 + CH_STRIDE, 8'h03);
    pulse(1'b1, 2);
    rd(A_COUNT + CH_STRIDE, q);
    chk_w(q, 32'h00000001);
    rd(A_IFLAG, q);
    chk_w(q, 32'h00000020);
    chk_b(irq, 1'b0);
    wr(A_IEN, 8'hA8);
    wait_n(2);
    chk_b(irq, 1'b1);
    wr(A_CTL1 + CH_STRIDE, 8'h00);
    wr(A_IFLAG, 8'h00);
    // second channel pins: prescaler-fed tone, idle active-low wave
    wr(A_CTL2 + CH_STRIDE, 8'h00);
    wr(A_TONE + CH_STRIDE, 8'h80);
    wr(A_CTL1 + CH_STRIDE, 8'hC1);
    wait_n(3);
    chk_b(wave2_oe_n | tone2_oe_n, 1'b0);
    watch(1'b1, 200, hi, tg);
    chk_w(hi, 200);
    chk_b(tg >= 49 && tg <= 51, 1'b1);
    wr(A_TONE + CH_STRIDE, 8'h00);
    wr(A_CTL1 + CH_STRIDE, 8'h00);
    wr(A_IFLAG, 8'h00);
    $display("test external tick done");
  endtask

  task automatic t_prescale();
    logic [31:0] q;
    wr(A_COUNT, 8'h50);
    wr(A_CTL2, 8'h21);
    wr(A_CTL1, 8'h01);
    pulse(1'b0, 9);
    rd(A_COUNT, q);
    chk_w(q, 32'h0000004E);
    rd(A_PSVAL, q);
    chk_w(q & 32'h00000003, 32'h00000001);
    wr(A_CTL1, 8'h00);
    $display("test prescaler done");
  endtask

  task automatic t_pwm();
    int hi;
    int tg;
    wr(A_CTL2, 8'h08);
    // duty kept at or below the reload value, as software must
    wr(A_DUTY, 8'h03);
    wr(A_COUNT, 8'h09);
    wr(A_CTL1, 8'h83);
    wait_n(5);
    chk_b(wave1_oe_n, 1'b0);
    watch(1'b0, 200, hi, tg);
    chk_b(hi >= 55 && hi <= 65, 1'b1);
    wr(A_CTL1, 8'hC3);
    watch(1'b0, 200, hi, tg);
    chk_b(hi >= 135 && hi <= 145, 1'b1);
    wr(A_CTL1, 8'h83);
    wr(A_DUTY, 8'h00);
    wait_n(25);
    watch(1'b0, 100, hi, tg);
    chk_w(hi, 0);
    wr(A_TONE, 8'h88);
    wait_n(5);
    chk_b(tone1_oe_n, 1'b0);
    watch(1'b0, 200, hi, tg);
    chk_b(tg >= 9 && tg <= 11, 1'b1);
    wr(A_TONE, 8'h00);
    wr(A_CTL1, 8'h00);
    wait_n(3);
    chk_b(tone1_oe_n & wave1_oe_n, 1'b1);
    chk_b(wave1, 1'b0);
    $display("test wave and tone done");
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hF;
    wdat = 32'h00000000;
    pin_a = 1'b0;
    pin_b = 1'b0;
    error_cnt = 0;
    total_checks = 0;
    wait_n(10);
    rst_n <= 1'b1;
    wait_n(2);
    t_reset();
    t_oneshot();
    t_reload();
    t_ext();
    t_prescale();
    t_pwm();
    end_sim();
  end
endmodule
